/* File: design/eac_pkg.sv */
package eac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned EAC_AW = 24;
  localparam int unsigned EAC_DW = 32;
  localparam int unsigned EAC_NREG = 8;

  // ----------------------------------------------------------------
  // Addressing mode codes on mode_i
  // ----------------------------------------------------------------
  localparam logic [3:0] EAC_MD_REG_DIRECT = 4'h0;
  localparam logic [3:0] EAC_MD_REG_IND = 4'h1;
  localparam logic [3:0] EAC_MD_REG_DISP = 4'h2;
  localparam logic [3:0] EAC_MD_POST_INC = 4'h3;
  localparam logic [3:0] EAC_MD_PRE_DEC = 4'h4;
  localparam logic [3:0] EAC_MD_ABSOLUTE = 4'h5;
  localparam logic [3:0] EAC_MD_IMMEDIATE = 4'h6;
  localparam logic [3:0] EAC_MD_PC_REL = 4'h7;
  localparam logic [3:0] EAC_MD_MEM_IND = 4'h8;
  localparam logic [3:0] EAC_MD_IMPLICIT = 4'h9;
  localparam logic [3:0] EAC_MD_BIT_NUM = 4'ha;
  localparam logic [3:0] EAC_MD_TRAP = 4'hb;

  // ----------------------------------------------------------------
  // Operand size and extension length codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EAC_SZ_BYTE = 2'h0;
  localparam logic [1:0] EAC_SZ_WORD = 2'h1;
  localparam logic [1:0] EAC_SZ_LONG = 2'h2;

  localparam logic [1:0] EAC_LEN_8 = 2'h0;
  localparam logic [1:0] EAC_LEN_16 = 2'h1;
  localparam logic [1:0] EAC_LEN_24 = 2'h2;
  localparam logic [1:0] EAC_LEN_32 = 2'h3;

  // ----------------------------------------------------------------
  // Fixed values
  // ----------------------------------------------------------------
  localparam logic [31:0] EAC_STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] EAC_STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] EAC_STEP_LONG = 32'h0000_0004;
  localparam logic [15:0] EAC_ABS8_FILL = 16'hffff;
  localparam logic [15:0] EAC_PTR_FILL = 16'h0000;
  localparam logic [7:0] EAC_PROG_HI = 8'h00;
  localparam int unsigned EAC_REG_SEL_BIT = 3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EAC_ST_IDLE = 2'b01,
    EAC_ST_PTR = 2'b10
  } eac_state_e_t;

endpackage

/* File: design/eac_reg_sel.sv */
`timescale 1ns/1ps
`default_nettype none

module eac_reg_sel (
  input wire logic [eac_pkg::EAC_NREG-1:0][eac_pkg::EAC_DW-1:0] gpr_i,
  input wire logic [3:0] field_i,
  input wire logic [1:0] size_i,
  output logic [eac_pkg::EAC_DW-1:0] operand_o
);
  import eac_pkg::*;

  logic [EAC_DW-1:0] full;
  logic hi_sel;

  assign full = gpr_i[field_i[2:0]];
  assign hi_sel = field_i[EAC_REG_SEL_BIT];

  // Narrow operands are zero-extended; the consumer uses only its width
  always_comb begin
    unique case (size_i)
      EAC_SZ_BYTE: operand_o = {24'h00_0000, (hi_sel ? full[7:0] : full[15:8])};
      EAC_SZ_WORD: operand_o = {16'h0000, (hi_sel ? full[31:16] : full[15:0])};
      default: operand_o = full;
    endcase
  end

endmodule

`default_nettype wire

/* File: design/eac_unit.sv */
// Overview of operation
// - Register direct picks byte halves, word halves or full registers as operand.
// - Register indirect program address keeps low 24 bits, upper 8 zero.
// - Displacement mode add_with_implicit_constant sign-extended 16-bit or 32-bit displacement to register.
// - Post-increment uses register, then writes back register plus 1, 2 or 4.
// - Pre-decrement subtracts 1, 2 or 4 first, uses and writes back result.
// - Word, longword or branch target at odd address clears the low bit.
// - 8-bit absolute data address fills upper bits with ones.
// - 16-bit absolute data address sign-extends into upper bits.
// - 32-bit absolute address reaches the whole space unmodified.
// - 24-bit absolute address is a program address, upper 8 bits zero.
// - Immediate mode passes the 8, 16 or 32-bit constant as operand.
// - Implicit-constant add, subtract, increment, decrement take value from opcode.
// - Bit instructions carry a 3-bit immediate selecting the bit number.
// - Trap instruction carries a 2-bit immediate selecting the vector address.
// - Branch add_with_implicit_constant sign-extended 8 or 16-bit displacement to 24-bit counter.
// - Counter base is the next instruction's first byte address.
// - Memory indirect zero-extends 8-bit pointer, reads branch target from it.
// - Pointer longword's first byte is zero; rest form the target.
`timescale 1ns/1ps
`default_nettype none

module eac_unit #(
  parameter logic [23:0] TRAP_VEC_BASE = 24'h00_0000,
  parameter int unsigned TRAP_VEC_SHIFT = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic req_valid_i,
  input wire logic [3:0] mode_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] ext_len_i,
  input wire logic [3:0] reg_field_i,
  input wire logic [eac_pkg::EAC_DW-1:0] ext_i,
  input wire logic is_program_i,
  input wire logic [1:0] implicit_sel_i,
  input wire logic [2:0] bit_num_i,
  input wire logic [1:0] trap_num_i,
  input wire logic [eac_pkg::EAC_AW-1:0] pc_next_i,
  input wire logic [eac_pkg::EAC_NREG-1:0][eac_pkg::EAC_DW-1:0] gpr_i,
  input wire logic mem_ack_i,
  input wire logic [eac_pkg::EAC_DW-1:0] mem_rdata_i,
  output logic ready_o,
  output logic done_o,
  output logic illegal_o,
  output logic ea_valid_o,
  output logic [eac_pkg::EAC_AW-1:0] ea_o,
  output logic operand_valid_o,
  output logic [eac_pkg::EAC_DW-1:0] operand_o,
  output logic wb_en_o,
  output logic [2:0] wb_reg_o,
  output logic [eac_pkg::EAC_DW-1:0] wb_data_o,
  output logic mem_rd_o,
  output logic [eac_pkg::EAC_AW-1:0] mem_addr_o
);
  import eac_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    eac_state_e_t state;
    logic ready;
    logic done;
    logic illegal;
    logic ea_valid;
    logic [EAC_AW-1:0] ea;
    logic operand_valid;
    logic [EAC_DW-1:0] operand;
    logic wb_en;
    logic [2:0] wb_reg;
    logic [EAC_DW-1:0] wb_data;
    logic mem_rd;
    logic [EAC_AW-1:0] mem_addr;
  } eac_regs_t;

  localparam eac_regs_t EAC_RESET = '{
    state: EAC_ST_IDLE,
    ready: 1'b1,
    done: 1'b0,
    illegal: 1'b0,
    ea_valid: 1'b0,
    ea: '0,
    operand_valid: 1'b0,
    operand: '0,
    wb_en: 1'b0,
    wb_reg: '0,
    wb_data: '0,
    mem_rd: 1'b0,
    mem_addr: '0
  };

  eac_regs_t st_q;
  eac_regs_t st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Hardware never faults on misalignment; it silently rounds down
  function automatic logic [EAC_AW-1:0] align_even(
    input logic [EAC_AW-1:0] addr,
    input logic force_even
  );
    align_even = {addr[EAC_AW-1:1], addr[0] & ~force_even};
  endfunction

  logic [EAC_DW-1:0] dir_operand;
  logic [EAC_DW-1:0] areg;
  logic [EAC_DW-1:0] step;
  logic [EAC_DW-1:0] disp32;
  logic [EAC_DW-1:0] disp_sum;
  logic [EAC_DW-1:0] post_sum;
  logic [EAC_DW-1:0] pre_diff;
  logic [EAC_AW-1:0] abs_addr;
  logic [EAC_AW-1:0] pc_disp;
  logic [EAC_AW-1:0] pc_target;
  logic [EAC_DW-1:0] imm_val;
  logic [EAC_DW-1:0] impl_val;
  logic [EAC_AW-1:0] trap_addr;
  logic wide;

  eac_reg_sel u_reg_sel (
    .gpr_i(gpr_i),
    .field_i(reg_field_i),
    .size_i(size_i),
    .operand_o(dir_operand)
  );

  assign areg = gpr_i[reg_field_i[2:0]];
  assign wide = (size_i != EAC_SZ_BYTE);

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    unique case (size_i)
      EAC_SZ_BYTE: step = EAC_STEP_BYTE;
      EAC_SZ_WORD: step = EAC_STEP_WORD;
      default: step = EAC_STEP_LONG;
    endcase
  end

  // 32-bit sums are formed in full, then cut to the address path
  assign disp32 = (ext_len_i == EAC_LEN_16) ? {{16{ext_i[15]}}, ext_i[15:0]} : ext_i;
  assign disp_sum = areg + disp32;
  assign post_sum = areg + step;
  assign pre_diff = areg - step;

  always_comb begin
    unique case (ext_len_i)
      EAC_LEN_8: abs_addr = {EAC_ABS8_FILL, ext_i[7:0]};
      EAC_LEN_16: abs_addr = {{8{ext_i[15]}}, ext_i[15:0]};
      EAC_LEN_24: abs_addr = ext_i[EAC_AW-1:0];
      default: abs_addr = ext_i[EAC_AW-1:0];
    endcase
  end

  // Counter already points past the branch, which sets the reach
  assign pc_disp = (ext_len_i == EAC_LEN_8) ? {{16{ext_i[7]}}, ext_i[7:0]}
                                            : {{8{ext_i[15]}}, ext_i[15:0]};
  assign pc_target = pc_next_i + pc_disp;

  always_comb begin
    unique case (ext_len_i)
      EAC_LEN_8: imm_val = {24'h00_0000, ext_i[7:0]};
      EAC_LEN_16: imm_val = {16'h0000, ext_i[15:0]};
      default: imm_val = ext_i;
    endcase
  end

  // Implicit constants: 1, 2 or 4 encoded in the opcode
  always_comb begin
    unique case (implicit_sel_i)
      2'h0: impl_val = EAC_STEP_BYTE;
      2'h1: impl_val = EAC_STEP_WORD;
      default: impl_val = EAC_STEP_LONG;
    endcase
  end

  assign trap_addr = TRAP_VEC_BASE + EAC_AW'({22'h00_0000, trap_num_i} << TRAP_VEC_SHIFT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.illegal = 1'b0;
    st_d.ea_valid = 1'b0;
    st_d.operand_valid = 1'b0;
    st_d.wb_en = 1'b0;
    unique case (st_q.state)
      EAC_ST_IDLE: begin
        if (req_valid_i) begin
          st_d.done = 1'b1;
          st_d.wb_reg = reg_field_i[2:0];
          unique case (mode_i)
            EAC_MD_REG_DIRECT: begin
              st_d.operand = dir_operand;
              st_d.operand_valid = 1'b1;
            end
            EAC_MD_REG_IND: begin
              if (is_program_i) begin
                st_d.ea = align_even(areg[EAC_AW-1:0], 1'b1);
              end else begin
                st_d.ea = align_even(areg[EAC_AW-1:0], wide);
              end
              st_d.ea_valid = 1'b1;
            end
            EAC_MD_REG_DISP: begin
              st_d.ea = align_even(disp_sum[EAC_AW-1:0], wide);
              st_d.ea_valid = 1'b1;
            end
            EAC_MD_POST_INC: begin
              st_d.ea = align_even(areg[EAC_AW-1:0], wide);
              st_d.ea_valid = 1'b1;
              st_d.wb_data = post_sum;
              st_d.wb_en = 1'b1;
            end
            EAC_MD_PRE_DEC: begin
              st_d.ea = align_even(pre_diff[EAC_AW-1:0], wide);
              st_d.ea_valid = 1'b1;
              st_d.wb_data = pre_diff;
              st_d.wb_en = 1'b1;
            end
            EAC_MD_ABSOLUTE: begin
              // A 24-bit form is a fetch target, so it is aligned as one
              st_d.ea = align_even(abs_addr, wide | (ext_len_i == EAC_LEN_24));
              st_d.ea_valid = 1'b1;
            end
            EAC_MD_IMMEDIATE: begin
              st_d.operand = imm_val;
              st_d.operand_valid = 1'b1;
            end
            EAC_MD_PC_REL: begin
              st_d.ea = align_even(pc_target, 1'b1);
              st_d.ea_valid = 1'b1;
            end
            EAC_MD_MEM_IND: begin
              // Result waits on the pointer read
              st_d.done = 1'b0;
              st_d.ready = 1'b0;
              st_d.mem_rd = 1'b1;
              st_d.mem_addr = {EAC_PTR_FILL, ext_i[7:0]};
              st_d.state = EAC_ST_PTR;
            end
            EAC_MD_IMPLICIT: begin
              st_d.operand = impl_val;
              st_d.operand_valid = 1'b1;
            end
            EAC_MD_BIT_NUM: begin
              st_d.operand = {29'h0000_0000, bit_num_i};
              st_d.operand_valid = 1'b1;
            end
            EAC_MD_TRAP: begin
              st_d.ea = trap_addr;
              st_d.ea_valid = 1'b1;
            end
            default: begin
              st_d.illegal = 1'b1;
            end
          endcase
        end
      end
      EAC_ST_PTR: begin
        if (mem_ack_i) begin
          st_d.mem_rd = 1'b0;
          st_d.ready = 1'b1;
          st_d.done = 1'b1;
          st_d.ea = align_even(mem_rdata_i[EAC_AW-1:0], 1'b1);
          st_d.ea_valid = 1'b1;
          st_d.state = EAC_ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_q <= EAC_RESET;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ready_o = st_q.ready;
  assign done_o = st_q.done;
  assign illegal_o = st_q.illegal;
  assign ea_valid_o = st_q.ea_valid;
  assign ea_o = st_q.ea;
  assign operand_valid_o = st_q.operand_valid;
  assign operand_o = st_q.operand;
  assign wb_en_o = st_q.wb_en;
  assign wb_reg_o = st_q.wb_reg;
  assign wb_data_o = st_q.wb_data;
  assign mem_rd_o = st_q.mem_rd;
  assign mem_addr_o = st_q.mem_addr;

endmodule

`default_nettype wire

/* File: sim/eac_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module eac_mem_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic rd_i,
  input wire logic [23:0] addr_i,
  input wire logic [3:0] wait_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [3:0] cnt;

  initial begin
    ack_o = 1'b0;
    rdata_o = 32'h0000_0000;
    cnt = 4'h0;
  end

  // Idle data toggles each cycle, so a read one cycle late sees inverted data; two cycles late it matches again
  always @(negedge clock_i) begin
    if (!sys_rst_i && rd_i && cnt >= wait_i) begin
      ack_o <= 1'b1;
      rdata_o <= {8'ha5, 8'h12, addr_i[7:0], 8'h57};
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end
    cnt <= (rd_i && !sys_rst_i) ? cnt + 4'h1 : 4'h0;
  end
endmodule

`default_nettype wire

/* File: sim/eac_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module eac_unit_monitor
  import eac_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic req_valid_i,
  input wire logic [3:0] mode_i,
  input wire logic [1:0] size_i,
  input wire logic [3:0] reg_field_i,
  input wire logic [31:0] ext_i,
  input wire logic [eac_pkg::EAC_NREG-1:0][eac_pkg::EAC_DW-1:0] gpr_i,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic ea_valid_o,
  input wire logic [23:0] ea_o,
  input wire logic operand_valid_o,
  input wire logic wb_en_o,
  input wire logic [2:0] wb_reg_o,
  input wire logic [31:0] wb_data_o,
  input wire logic mem_rd_o,
  input wire logic [23:0] mem_addr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  logic take;
  logic [3:0] md_q;
  logic [2:0] rf_q;
  logic [7:0] ptr_q;
  logic [31:0] base_q;
  logic [31:0] step_q;
  logic [23:0] tgt_q;
  assign take = clk_en_i && req_valid_i && ready_o;

  always_ff @(posedge clock_i) begin
    tgt_q <= {mem_rdata_i[23:1], 1'b0};
    if (take) begin
      md_q <= mode_i;
      rf_q <= reg_field_i[2:0];
      ptr_q <= ext_i[7:0];
      base_q <= gpr_i[reg_field_i[2:0]];
      step_q <= (size_i == EAC_SZ_BYTE) ? 32'h1 : (size_i == EAC_SZ_WORD) ? 32'h2 : 32'h4;
    end
  end

  done_lat_a: assert property (take && mode_i != EAC_MD_MEM_IND |=> done_o)
    else $error("done missing one cycle after request");
  ptr_addr_a: assert property (take && mode_i == EAC_MD_MEM_IND |=>
    mem_rd_o && !ready_o && mem_addr_o == {16'h0000, ptr_q}) else $error("pointer read wrong");
  busy_hold_a: assert property (mem_rd_o |-> !ready_o)
    else $error("ready while pointer read open");
  ptr_target_a: assert property (clk_en_i && mem_rd_o && mem_ack_i |=>
    done_o && ea_valid_o && ea_o == tgt_q) else $error("pointer target wrong");
  ready_back_a: assert property ($rose(ready_o) |-> done_o && ea_valid_o)
    else $error("ready returned without result");
  post_inc_a: assert property (wb_en_o && md_q == EAC_MD_POST_INC |->
    wb_reg_o == rf_q && wb_data_o == base_q + step_q) else $error("post-increment write-back wrong");
  pre_dec_a: assert property (wb_en_o && md_q == EAC_MD_PRE_DEC |->
    wb_data_o == base_q - step_q && ea_o[23:1] == wb_data_o[23:1]) else $error("pre-decrement wrong");
  branch_even_a: assert property (ea_valid_o && md_q == EAC_MD_PC_REL |-> !ea_o[0])
    else $error("odd branch target");
  imm_nomem_a: assert property (take && mode_i == EAC_MD_IMMEDIATE |=>
    operand_valid_o && !mem_rd_o) else $error("immediate not delivered");
endmodule

bind eac_unit eac_unit_monitor u_eac_unit_monitor (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
  .mode_i(mode_i), .size_i(size_i), .reg_field_i(reg_field_i), .ext_i(ext_i), .gpr_i(gpr_i),
  .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .ready_o(ready_o), .done_o(done_o),
  .ea_valid_o(ea_valid_o), .ea_o(ea_o), .operand_valid_o(operand_valid_o), .wb_en_o(wb_en_o),
  .wb_reg_o(wb_reg_o), .wb_data_o(wb_data_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o)
);

`default_nettype wire

/* File: sim/eac_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module eac_unit_tb;
  import eac_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic is_program_i = 1'b0;
  logic [3:0] mode_i = 4'h0;
  logic [3:0] reg_field_i = 4'h0;
  logic [1:0] size_i = 2'h0;
  logic [1:0] ext_len_i = 2'h0;
  logic [1:0] implicit_sel_i = 2'h0;
  logic [1:0] trap_num_i = 2'h0;
  logic [2:0] bit_num_i = 3'h0;
  logic [31:0] ext_i = 32'h0;
  logic [23:0] pc_next_i = 24'h0;
  logic [EAC_NREG-1:0][EAC_DW-1:0] gpr_i = '0;
  logic [3:0] mem_wait = 4'h0;
  logic mem_ack_i, ready_o, done_o, illegal_o, ea_valid_o, operand_valid_o, wb_en_o, mem_rd_o;
  logic [31:0] mem_rdata_i, operand_o, wb_data_o;
  logic [23:0] ea_o, mem_addr_o;
  logic [2:0] wb_reg_o;
  int num_errors = 0;
  int comparisons = 0;

  initial forever #4 clock_i = ~clock_i;

  eac_unit #(.TRAP_VEC_BASE(24'h000100), .TRAP_VEC_SHIFT(2)) u_eac_unit (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
    .mode_i(mode_i), .size_i(size_i), .ext_len_i(ext_len_i), .reg_field_i(reg_field_i),
    .ext_i(ext_i), .is_program_i(is_program_i), .implicit_sel_i(implicit_sel_i),
    .bit_num_i(bit_num_i), .trap_num_i(trap_num_i), .pc_next_i(pc_next_i), .gpr_i(gpr_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .ready_o(ready_o), .done_o(done_o),
    .illegal_o(illegal_o), .ea_valid_o(ea_valid_o), .ea_o(ea_o), .operand_valid_o(operand_valid_o),
    .operand_o(operand_o), .wb_en_o(wb_en_o), .wb_reg_o(wb_reg_o), .wb_data_o(wb_data_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o));

  eac_mem_model u_eac_mem_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .rd_i(mem_rd_o),
    .addr_i(mem_addr_o), .wait_i(mem_wait), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // ----
  // Request driver: one request, then wait for the result pulse
  // ----
  task automatic issue(input logic [3:0] md, input logic [1:0] sz, input logic [1:0] ln,
                       input logic [3:0] rf, input logic [31:0] ex);
    int n;
    n = 0;
    // Let an edge pass so the request line never drops and rises in one step
    @(negedge clock_i);
    mode_i = md;
    size_i = sz;
    ext_len_i = ln;
    reg_field_i = rf;
    ext_i = ex;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      $display("[ERR] done exp 1 got 0");
    end
  endtask

  task automatic t_reg_direct;
    gpr_i[3] = 32'h89ab_cdef;
    issue(EAC_MD_REG_DIRECT, EAC_SZ_BYTE, EAC_LEN_8, 4'h3, 32'h0);
    `CHECK_EQ("rd_hi", 32'h0000_00cd, operand_o)
    issue(EAC_MD_REG_DIRECT, EAC_SZ_BYTE, EAC_LEN_8, 4'hb, 32'h0);
    `CHECK_EQ("rd_lo", 32'h0000_00ef, operand_o)
    issue(EAC_MD_REG_DIRECT, EAC_SZ_WORD, EAC_LEN_8, 4'hb, 32'h0);
    `CHECK_EQ("rd_ext", 32'h0000_89ab, operand_o)
    issue(EAC_MD_REG_DIRECT, EAC_SZ_LONG, EAC_LEN_8, 4'h3, 32'h0);
    `CHECK_EQ("rd_full", 32'h89ab_cdef, operand_o)
  endtask

  task automatic t_reg_ind;
    gpr_i[1] = 32'hff12_3457;
    gpr_i[4] = 32'h0000_1000;
    is_program_i = 1'b1;
    issue(EAC_MD_REG_IND, EAC_SZ_BYTE, EAC_LEN_8, 4'h1, 32'h0);
    `CHECK_EQ("prog_ind", 24'h123456, ea_o)
    is_program_i = 1'b0;
    issue(EAC_MD_REG_IND, EAC_SZ_BYTE, EAC_LEN_8, 4'h1, 32'h0);
    `CHECK_EQ("data_ind", 24'h123457, ea_o)
    issue(EAC_MD_REG_DISP, EAC_SZ_BYTE, EAC_LEN_16, 4'h4, 32'h0000_8000);
    `CHECK_EQ("disp16", 24'hff9000, ea_o)
    issue(EAC_MD_REG_DISP, EAC_SZ_BYTE, EAC_LEN_32, 4'h4, 32'h0100_0010);
    `CHECK_EQ("disp32", 24'h001010, ea_o)
  endtask

  task automatic t_auto_step;
    for (int i = 0; i < 3; i++) begin
      gpr_i[2] = 32'h0000_1000;
      issue(EAC_MD_POST_INC, i[1:0], EAC_LEN_8, 4'h2, 32'h0);
      `CHECK_EQ("inc_ea", 24'h001000, ea_o)
      `CHECK_EQ("inc_wb", 32'h0000_1000 + (32'h1 << i), wb_data_o)
      `CHECK_EQ("inc_wen", 1'b1, wb_en_o)
      issue(EAC_MD_PRE_DEC, i[1:0], EAC_LEN_8, 4'h2, 32'h0);
      `CHECK_EQ("dec_ea", 24'h001000 - (24'h1 << i), ea_o)
      `CHECK_EQ("dec_wb", 32'h0000_1000 - (32'h1 << i), wb_data_o)
    end
    gpr_i[2] = 32'h0000_1001;
    issue(EAC_MD_POST_INC, EAC_SZ_WORD, EAC_LEN_8, 4'h2, 32'h0);
    `CHECK_EQ("inc_odd", 24'h001000, ea_o)
  endtask

  task automatic t_absolute;
    logic [1:0] ln [5] = '{EAC_LEN_8, EAC_LEN_16, EAC_LEN_16, EAC_LEN_32, EAC_LEN_24};
    logic [31:0] ex [5] = '{32'h34, 32'h7fff, 32'h8000, 32'h00ab_cdef, 32'h0012_3457};
    logic [23:0] ea [5] = '{24'hffff34, 24'h007fff, 24'hff8000, 24'habcdef, 24'h123456};
    for (int i = 0; i < 5; i++) begin
      issue(EAC_MD_ABSOLUTE, EAC_SZ_BYTE, ln[i], 4'h0, ex[i]);
      `CHECK_EQ("abs_ea", ea[i], ea_o)
    end
    issue(EAC_MD_ABSOLUTE, EAC_SZ_WORD, EAC_LEN_16, 4'h0, 32'h1235);
    `CHECK_EQ("abs_odd", 24'h001234, ea_o)
  endtask

  task automatic t_constants;
    issue(EAC_MD_IMMEDIATE, EAC_SZ_BYTE, EAC_LEN_8, 4'h0, 32'hdead_beef);
    `CHECK_EQ("imm8", 32'h0000_00ef, operand_o)
    issue(EAC_MD_IMMEDIATE, EAC_SZ_WORD, EAC_LEN_16, 4'h0, 32'hdead_beef);
    `CHECK_EQ("imm16", 32'h0000_beef, operand_o)
    issue(EAC_MD_IMMEDIATE, EAC_SZ_LONG, EAC_LEN_32, 4'h0, 32'hdead_beef);
    `CHECK_EQ("imm32", 32'hdead_beef, operand_o)
    for (int i = 0; i < 4; i++) begin
      implicit_sel_i = i[1:0];
      trap_num_i = i[1:0];
      bit_num_i = 3'(2 * i + 1);
      issue(EAC_MD_IMPLICIT, EAC_SZ_LONG, EAC_LEN_8, 4'h0, 32'h0);
      `CHECK_EQ("implicit", (i == 0) ? 32'h1 : (i == 1) ? 32'h2 : 32'h4, operand_o)
      issue(EAC_MD_BIT_NUM, EAC_SZ_BYTE, EAC_LEN_8, 4'h0, 32'h0);
      `CHECK_EQ("bit_num", 32'(2 * i + 1), operand_o)
      issue(EAC_MD_TRAP, EAC_SZ_LONG, EAC_LEN_8, 4'h0, 32'h0);
      `CHECK_EQ("trap_vec", 24'(256 + 4 * i), ea_o)
    end
    issue(4'hc, EAC_SZ_BYTE, EAC_LEN_8, 4'h0, 32'h0);
    `CHECK_EQ("illegal", 1'b1, illegal_o)
    `CHECK_EQ("illegal_ea", 1'b0, ea_valid_o)
  endtask

  // Frozen clock enable must hold a pending request untaken
  task automatic t_stall;
    @(negedge clock_i);
    clk_en_i = 1'b0;
    mode_i = EAC_MD_IMMEDIATE;
    ext_len_i = EAC_LEN_8;
    ext_i = 32'h0000_005a;
    req_valid_i = 1'b1;
    repeat (3) @(negedge clock_i);
    `CHECK_EQ("stall_done", 1'b0, done_o)
    clk_en_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    `CHECK_EQ("stall_done", 1'b1, done_o)
    `CHECK_EQ("stall_imm", 32'h0000_005a, operand_o)
  endtask

  task automatic t_pc_rel;
    pc_next_i = 24'h001000;
    issue(EAC_MD_PC_REL, EAC_SZ_BYTE, EAC_LEN_8, 4'h0, 32'h80);
    `CHECK_EQ("br8_back", 24'h000f80, ea_o)
    issue(EAC_MD_PC_REL, EAC_SZ_BYTE, EAC_LEN_8, 4'h0, 32'h7f);
    `CHECK_EQ("br8_odd", 24'h00107e, ea_o)
    issue(EAC_MD_PC_REL, EAC_SZ_BYTE, EAC_LEN_16, 4'h0, 32'h8002);
    `CHECK_EQ("br16_back", 24'hff9002, ea_o)
    pc_next_i = 24'hfffff0;
    issue(EAC_MD_PC_REL, EAC_SZ_BYTE, EAC_LEN_16, 4'h0, 32'h20);
    `CHECK_EQ("br_wrap", 24'h000010, ea_o)
  endtask

  task automatic t_mem_ind;
    for (int w = 0; w < 4; w += 3) begin
      mem_wait = w[3:0];
      issue(EAC_MD_MEM_IND, EAC_SZ_LONG, EAC_LEN_8, 4'h0, 32'hffff_ff40 | w);
      `CHECK_EQ("ptr_addr", {16'h0000, 8'h40 | 8'(w)}, mem_addr_o)
      `CHECK_EQ("ptr_tgt", {8'h12, 8'h40 | 8'(w), 8'h56}, ea_o)
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    $display("[ERR] watchdog exp finish got timeout");
    tally_and_finish();
  end

  initial begin
    repeat (2) @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_reg_direct();
    t_reg_ind();
    t_auto_step();
    t_absolute();
    t_constants();
    t_pc_rel();
    t_mem_ind();
    t_stall();
    tally_and_finish();
  end
endmodule

`default_nettype wire
